// File: pkg/scrb_pkg.sv
// constants for the system control register bank: map, reset values, masks, fields
// assumes a 32-bit apb slave port and a single bus clock
package scrb_pkg;

  // ******************************************************************
  // bank geometry
  // ******************************************************************
  localparam int          SCRB_NREG        = 48;
  localparam int          SCRB_IW          = 6;
  localparam int          SCRB_AW          = 14;
  localparam int          SCRB_OW          = 12;
  localparam logic [31:0] SCRB_BANK_BASE   = 32'h4004_8000;
  // flash timing lives in the flash controller at this base, not here
  localparam logic [31:0] SCRB_FLASH_BASE  = 32'h4003_c000;

  // ******************************************************************
  // register offsets, one word each, in index order
  // ******************************************************************
  localparam logic [SCRB_OW-1:0] SCRB_OFFSET [SCRB_NREG] = '{
    12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h020, 12'h024,
    12'h028, 12'h030, 12'h040, 12'h044, 12'h048, 12'h04c, 12'h070, 12'h074,
    12'h078, 12'h080, 12'h094, 12'h098, 12'h09c, 12'h0c0, 12'h0c4, 12'h0c8,
    12'h0e0, 12'h0e4, 12'h0e8, 12'h100, 12'h104, 12'h150, 12'h154, 12'h170,
    12'h174, 12'h178, 12'h17c, 12'h180, 12'h184, 12'h188, 12'h18c, 12'h190,
    12'h194, 12'h198, 12'h19c, 12'h204, 12'h214, 12'h230, 12'h234, 12'h238};

  // ******************************************************************
  // reset values of the stored words
  // ******************************************************************
  localparam logic [31:0] SCRB_RESET [SCRB_NREG] = '{
    32'h2, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h80, 32'h3, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 32'h1,
    32'h1, 32'h3f, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h10,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'hffff, 32'hedf0, 32'hedd0};

  // ******************************************************************
  // writable bits of the stored words; zero where the main block owns it
  // ******************************************************************
  localparam logic [31:0] SCRB_WMASK [SCRB_NREG] = '{
    32'h0, 32'h7, 32'h7f, 32'h0, 32'h7f, 32'h0, '1, '1,
    '1, 32'h0, '1, '1, '1, '1, '1, '1,
    '1, '1, '1, '1, '1, '1, '1, '1,
    '1, '1, '1, 32'h0, 32'h0, '1, '1, 32'h0,
    '1, '1, '1, '1, '1, '1, '1, '1,
    '1, '1, 32'h0, '1, '1, '1, '1, '1};

  // ******************************************************************
  // words held in the main block instead of the store
  // ******************************************************************
  localparam logic [SCRB_IW-1:0] SCRB_IDX_REMAP    = 6'd0;
  localparam logic [SCRB_IW-1:0] SCRB_IDX_SPLL_ST  = 6'd3;
  localparam logic [SCRB_IW-1:0] SCRB_IDX_UPLL_ST  = 6'd5;
  localparam logic [SCRB_IW-1:0] SCRB_IDX_RST_ST   = 6'd9;
  localparam logic [SCRB_IW-1:0] SCRB_IDX_PORCAP0  = 6'd27;
  localparam logic [SCRB_IW-1:0] SCRB_IDX_PORCAP1  = 6'd28;
  localparam logic [SCRB_IW-1:0] SCRB_IDX_IRQ_DLY  = 6'd31;
  localparam logic [SCRB_IW-1:0] SCRB_IDX_USBCK_ST = 6'd42;

  // ******************************************************************
  // fields
  // ******************************************************************
  localparam int          SCRB_MAP_W        = 2;
  localparam logic [1:0]  SCRB_MAP_RESET    = 2'h2;
  localparam logic [1:0]  SCRB_MAP_ROM      = 2'h0;
  localparam logic [1:0]  SCRB_MAP_RAM      = 2'h1;
  localparam logic [1:0]  SCRB_MAP_FLASH    = 2'h2;
  localparam logic [31:0] SCRB_REMAP_LIMIT  = 32'h0000_0200;
  localparam int          SCRB_IRQ_DLY_W    = 8;
  localparam logic [7:0]  SCRB_IRQ_DLY_RST  = 8'h10;
  localparam int          SCRB_RST_ST_W     = 5;
  localparam logic [4:0]  SCRB_RST_ST_RST   = 5'h03;
  localparam int          SCRB_STRAP_W      = 64;

endpackage

// File: logic/scrb_regmem.sv
// word store of the register bank, with per-word reset values and write masks
// assumes index decode and bus timing are done by the instantiating block
module scrb_regmem
#(
  parameter int N  = scrb_pkg::SCRB_NREG,
  parameter int IW = scrb_pkg::SCRB_IW
)
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [IW-1:0] widx,
  input  wire logic [31:0]   wdata,
  input  wire logic          re,
  input  wire logic [IW-1:0] ridx,
  output logic      [31:0]   rdata
);
  import scrb_pkg::*;

  logic [31:0] mem_r [N];

  // ******************************************************************
  // storage: masked bits keep their value, so reserved bits stay zero
  // ******************************************************************
  for (genvar i = 0; i < N; i++)
  begin : g_word
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        mem_r[i] <= SCRB_RESET[i];
      else if (ce && we && widx == IW'(i))
        mem_r[i] <= (mem_r[i] & ~SCRB_WMASK[i]) | (wdata & SCRB_WMASK[i]);
    end
  end

  // read port is registered so the bank read mux stays shallow
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 32'h0;
    else if (ce && re)
      rdata <= mem_r[ridx];
  end

endmodule

// File: logic/scrb_bank.sv
// system control register bank: apb slave, vector remap control and decode,
// interrupt delay setting, reset source status and pin state capture
// assumes pclk drives the whole bank; status and strap pins arrive asynchronously
//
// Notes on behaviour
// - every register sits on its own aligned 32-bit word at a fixed offset from the bank base.
// - the vector source field at bits 1:0 resets to 0x2 so flash sits at address zero.
// - vector source 0x0 selects boot rom, 0x1 static ram and 0x2 flash without remapping.
// - a rom or ram selection redirects only the lowest 512 bytes starting at address zero.
// - the bank holds an interrupt delay setting that resets to 0x10.
// - the flash timing register belongs to another block and is not decoded here.
//
// The APB register port was decided locally.
module scrb_bank
(
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              pce,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [scrb_pkg::SCRB_AW-1:0]      paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic                              sys_pll_lock,
  input  wire logic                              usb_pll_lock,
  input  wire logic                              usb_clk_state,
  input  wire logic [scrb_pkg::SCRB_STRAP_W-1:0] strap_pins,
  input  wire logic [scrb_pkg::SCRB_RST_ST_W-1:0] reset_cause,
  input  wire logic [31:0]                       fetch_addr,
  output logic      [scrb_pkg::SCRB_MAP_W-1:0]   vector_remap_register,
  output logic                                   vector_from_rom,
  output logic                                   vector_from_ram,
  output logic      [scrb_pkg::SCRB_IRQ_DLY_W-1:0] interrupt_delay_setting
);
  import scrb_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_DONE} scrb_state_e;

  // ******************************************************************
  // address decode
  // ******************************************************************

  // returns {hit, index}; misaligned or out-of-bank addresses miss
  // a compare per word costs gates but keeps the whole map in one constant table
  function automatic logic [SCRB_IW:0] scrb_decode(input logic [SCRB_AW-1:0] a);
    logic [SCRB_IW:0] res;
    res = '0;
    if (a[SCRB_AW-1:SCRB_OW] == '0 && a[1:0] == 2'b00)
    begin
      for (int k = 0; k < SCRB_NREG; k++)
      begin
        if (a[SCRB_OW-1:0] == SCRB_OFFSET[k])
          res = {1'b1, SCRB_IW'(k)};
      end
    end
    return res;
  endfunction

  scrb_state_e state_r;
  scrb_state_e state_nxt;

  logic [SCRB_IW:0]        dec_setup;
  logic                    setup_hit;
  logic [SCRB_IW-1:0]      setup_idx;
  logic                    setup_cyc;
  logic                    access_done;

  logic [SCRB_IW-1:0]      idx_r;
  logic                    hit_r;
  logic                    wr_r;
  logic [31:0]             mem_rdata;

  // decode is taken in the setup cycle and held for the rest of the transfer
  assign dec_setup   = scrb_decode(paddr);
  assign setup_hit   = dec_setup[SCRB_IW];
  assign setup_idx   = dec_setup[SCRB_IW-1:0];
  assign setup_cyc   = psel && !penable && state_r == ST_IDLE;
  assign access_done = psel && penable && pready;

  // ******************************************************************
  // synchronisers for asynchronous status and strap inputs
  // ******************************************************************
  logic [2:0]              stat_s1_r;
  logic [2:0]              stat_s2_r;
  logic [SCRB_STRAP_W-1:0] strap_s1_r;
  logic [SCRB_STRAP_W-1:0] strap_s2_r;

  // status flags: first stage is read only by the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_s1_r <= '0;
      stat_s2_r <= '0;
    end
    else if (pce)
    begin
      stat_s1_r <= {usb_clk_state, usb_pll_lock, sys_pll_lock};
      stat_s2_r <= stat_s1_r;
    end
  end

  // strap pins: a pin that moves during capture may settle either way
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_s1_r <= '0;
      strap_s2_r <= '0;
    end
    else if (pce)
    begin
      strap_s1_r <= strap_pins;
      strap_s2_r <= strap_s1_r;
    end
  end

  // ******************************************************************
  // strap capture after reset release
  // ******************************************************************
  logic                    cap_cnt_done_r;
  logic [1:0]              cap_cnt_r;
  logic [SCRB_STRAP_W-1:0] strap_cap_r;

  // wait until the synchroniser has filled with real pin levels, then latch once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_cnt_r      <= 2'h0;
      cap_cnt_done_r <= 1'b0;
      strap_cap_r    <= '0;
    end
    else if (pce && !cap_cnt_done_r)
    begin
      cap_cnt_r <= cap_cnt_r + 2'h1;
      if (cap_cnt_r == 2'h2)
      begin
        cap_cnt_done_r <= 1'b1;
        strap_cap_r    <= strap_s2_r;
      end
    end
  end

  // ******************************************************************
  // transfer sequencer: setup -> load read data -> complete
  // ******************************************************************
  // pce low holds the sequencer where it is, so a frozen transfer resumes intact;
  // the unused fourth state code falls back to idle
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (setup_cyc) state_nxt = ST_LOAD;
      ST_LOAD: state_nxt = ST_DONE;
      ST_DONE: if (access_done) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= ST_IDLE;
    else if (pce)
      state_r <= state_nxt;
  end

  // request attributes are frozen at the setup edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idx_r <= '0;
      hit_r <= 1'b0;
      wr_r  <= 1'b0;
    end
    else if (pce && setup_cyc)
    begin
      idx_r <= setup_idx;
      hit_r <= setup_hit;
      wr_r  <= pwrite;
    end
  end

  // ******************************************************************
  // write strobes
  // ******************************************************************
  logic write_go;
  logic wr_remap;
  logic wr_irq;
  logic wr_rst;

  // unmapped writes reach no storage at all
  // a write to a read-only word completes on the bus but changes nothing
  assign write_go = access_done && wr_r && hit_r;
  assign wr_remap = write_go && idx_r == SCRB_IDX_REMAP;
  assign wr_irq   = write_go && idx_r == SCRB_IDX_IRQ_DLY;
  assign wr_rst   = write_go && idx_r == SCRB_IDX_RST_ST;

  scrb_regmem
  #(
    .N  (SCRB_NREG),
    .IW (SCRB_IW)
  )
  u_store
  (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (pce),
    .we    (write_go),
    .widx  (idx_r),
    .wdata (pwdata),
    .re    (setup_cyc),
    .ridx  (setup_idx),
    .rdata (mem_rdata)
  );

  // ******************************************************************
  // registers held locally because they steer logic or show live state
  // ******************************************************************
  logic [SCRB_RST_ST_W-1:0] rst_stat_r;
  logic [SCRB_RST_ST_W-1:0] rst_stat_nxt;

  // write one to clear; a cause arriving in the same cycle survives the clear
  assign rst_stat_nxt = (rst_stat_r & ~(wr_rst ? pwdata[SCRB_RST_ST_W-1:0] : '0))
                        | reset_cause;

  // vector source field: only bits 1:0 are kept, the reserved code is stored as written
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vector_remap_register <= SCRB_MAP_RESET;
    else if (pce && wr_remap)
      vector_remap_register <= pwdata[SCRB_MAP_W-1:0];
  end

  // interrupt delay setting: software trades latency against determinism with it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      interrupt_delay_setting <= SCRB_IRQ_DLY_RST;
    else if (pce && wr_irq)
      interrupt_delay_setting <= pwdata[SCRB_IRQ_DLY_W-1:0];
  end

  // reset cause bits follow their next value on every enabled edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_stat_r <= SCRB_RST_ST_RST;
    else if (pce)
      rst_stat_r <= rst_stat_nxt;
  end

  // ******************************************************************
  // vector fetch redirect
  // ******************************************************************
  logic in_window;
  logic sel_rom;
  logic sel_ram;

  // only the bottom 512 bytes move; code 0x3 falls back to flash
  assign in_window = fetch_addr < SCRB_REMAP_LIMIT;
  assign sel_rom   = in_window && vector_remap_register == SCRB_MAP_ROM;
  assign sel_ram   = in_window && vector_remap_register == SCRB_MAP_RAM;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vector_from_rom <= 1'b0;
    else if (pce)
      vector_from_rom <= sel_rom;
  end

  // ram flag has the same one-cycle lag as the rom flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vector_from_ram <= 1'b0;
    else if (pce)
      vector_from_ram <= sel_ram;
  end

  // ******************************************************************
  // read mux and apb answer
  // ******************************************************************
  logic [31:0] rd_mux;

  // local words override the store; upper bits pad with zero
  assign rd_mux =
    !hit_r                       ? 32'h0 :
    idx_r == SCRB_IDX_REMAP      ? {30'h0, vector_remap_register} :
    idx_r == SCRB_IDX_IRQ_DLY    ? {24'h0, interrupt_delay_setting} :
    idx_r == SCRB_IDX_RST_ST     ? {27'h0, rst_stat_r} :
    idx_r == SCRB_IDX_SPLL_ST    ? {31'h0, stat_s2_r[0]} :
    idx_r == SCRB_IDX_UPLL_ST    ? {31'h0, stat_s2_r[1]} :
    idx_r == SCRB_IDX_USBCK_ST   ? {31'h0, stat_s2_r[2]} :
    idx_r == SCRB_IDX_PORCAP0    ? strap_cap_r[31:0] :
    idx_r == SCRB_IDX_PORCAP1    ? strap_cap_r[63:32] :
                                   mem_rdata;

  // answer is raised one cycle into the access phase and dropped on completion
  logic load_go;
  logic done_go;

  assign load_go = pce && state_r == ST_LOAD;
  assign done_go = pce && access_done;

  // read data shows only in the answer cycle, so an idle bus reads as zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (load_go)
      prdata <= wr_r ? 32'h0 : rd_mux;
    else if (done_go)
      prdata <= 32'h0;
  end

  // ready stands for exactly one cycle per transfer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else if (load_go)
      pready <= 1'b1;
    else if (done_go)
      pready <= 1'b0;
  end

  // error travels with ready; unmapped and misaligned words are refused
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else if (load_go)
      pslverr <= !hit_r;
    else if (done_go)
      pslverr <= 1'b0;
  end

endmodule

// File: test/scrb_bank_monitor.sv
// checker for the register bank: apb answer timing, remap decode, reset values
// assumes it is bound to scrb_bank and sees only that module's ports
module scrb_bank_monitor
(
  input wire logic                            pclk,
  input wire logic                            presetn,
  input wire logic                            pce,
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [scrb_pkg::SCRB_AW-1:0]    paddr,
  input wire logic [31:0]                     pwdata,
  input wire logic [31:0]                     prdata,
  input wire logic                            pready,
  input wire logic                            pslverr,
  input wire logic [31:0]                     fetch_addr,
  input wire logic [scrb_pkg::SCRB_MAP_W-1:0] vector_remap_register,
  input wire logic                            vector_from_rom,
  input wire logic                            vector_from_ram,
  input wire logic [7:0]                      interrupt_delay_setting
);
  import scrb_pkg::*;

  // ****************************************
  // sequences and properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // setup seen only while idle, so a back-to-back answer is not mistaken for one
  sequence setup_s;
    pce && psel && !penable && !pready;
  endsequence
  sequence answer_s;
    !pready ##1 pready ##1 !pready;
  endsequence
  sequence wr_s(logic [13:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence

  ready_timing_a: assert property (setup_s |=> answer_s)
    else $error("apb answer not after one wait state");
  reset_values_a: assert property ($rose(presetn) |->
    vector_remap_register == 2'h2 && interrupt_delay_setting == 8'h10)
    else $error("remap or delay wrong after reset");
  map_write_a: assert property (wr_s(14'h000) |=>
    32'(vector_remap_register) == ($past(pwdata) & 32'h3))
    else $error("remap field did not take write");
  delay_write_a: assert property (wr_s(14'h170) |=>
    32'(interrupt_delay_setting) == ($past(pwdata) & 32'hff))
    else $error("delay setting did not take write");
  reserved_read_a: assert property (pready && !pwrite && !pslverr && paddr == 14'h000 |->
    prdata == {30'h0, vector_remap_register})
    else $error("remap word read wrong");
  bank_error_a: assert property (pready && (paddr[1:0] != 2'h0 ||
    paddr[13:12] != 2'h0 || paddr == 14'h3f4) |-> pslverr)
    else $error("access outside bank not refused");
  rom_decode_a: assert property (pce && fetch_addr < 32'h200 &&
    vector_remap_register == 2'h0 |=> vector_from_rom && !vector_from_ram)
    else $error("boot rom window not selected");
  ram_decode_a: assert property (pce && fetch_addr < 32'h200 &&
    vector_remap_register == 2'h1 |=> vector_from_ram && !vector_from_rom)
    else $error("ram window not selected");
  window_limit_a: assert property (pce && fetch_addr >= 32'h200 |=>
    !vector_from_rom && !vector_from_ram)
    else $error("redirect beyond lowest 512 bytes");
  flash_nomap_a: assert property (pce && vector_remap_register[1] |=>
    !vector_from_rom && !vector_from_ram)
    else $error("flash mode still redirects");
endmodule

bind scrb_bank scrb_bank_monitor u_mon (.pclk(pclk), .presetn(presetn), .pce(pce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .fetch_addr(fetch_addr),
  .vector_remap_register(vector_remap_register), .vector_from_rom(vector_from_rom),
  .vector_from_ram(vector_from_ram), .interrupt_delay_setting(interrupt_delay_setting));

// File: test/scrb_bank_tb.sv
// self-checking bench for the register bank, driven over apb
// assumes scrb_bank as the top design module with its checker bound
module scrb_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scrb_pkg::*;

  typedef struct {logic wr; logic [13:0] a; logic [31:0] d; logic [31:0] e; logic err;} scrb_row_s;

  // ****************************************
  // signals
  // ****************************************
  logic        pclk = 1'b0, presetn = 1'b0, pce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pll_s = 1'b1, pll_u = 1'b0, ck_st = 1'b1;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0, fetch_addr = 32'h1000, prdata, rd;
  logic        pready, pslverr, rom, ram, err;
  logic [1:0]  vmap;
  logic [7:0]  dly;
  logic [4:0]  reset_cause = '0;
  logic [63:0] strap_pins = 64'h0123_4567_89ab_cdef;
  logic [31:0] fa [3] = '{32'h0, 32'h1fc, 32'h200};
  int          err_count = 0, comparisons = 0, cycles = 0;
  // write rows carry no read value; reserved offsets are only read, never written
  scrb_row_s   rows [22] = '{
    '{0, 14'h00c, 0, 32'h1, 0}, '{0, 14'h014, 0, 32'h0, 0}, '{0, 14'h19c, 0, 32'h1, 0},
    '{0, 14'h100, 0, 32'h89ab_cdef, 0}, '{0, 14'h104, 0, 32'h0123_4567, 0},
    '{1, 14'h000, 32'hffff_fffc, 0, 0}, '{0, 14'h000, 0, 32'h0, 0},
    '{1, 14'h000, 32'h1, 0, 0}, '{0, 14'h000, 0, 32'h1, 0},
    '{1, 14'h170, 32'hffff_ffff, 0, 0}, '{0, 14'h170, 0, 32'hff, 0},
    '{1, 14'h004, 32'hffff_ffff, 0, 0}, '{0, 14'h004, 0, 32'h7, 0},
    '{1, 14'h238, 32'ha5a5_5a5a, 0, 0}, '{0, 14'h238, 0, 32'ha5a5_5a5a, 0},
    '{1, 14'h00c, 32'hffff_ffff, 0, 0}, '{0, 14'h00c, 0, 32'h1, 0},
    '{0, 14'h0cc, 0, 32'h0, 1}, '{0, 14'h02c, 0, 32'h0, 1},
    '{0, 14'h3f4, 0, 32'h0, 1}, '{0, 14'h1010, 0, 32'h0, 1}, '{0, 14'h002, 0, 32'h0, 1}};

  always #12.5 pclk = ~pclk;

  scrb_bank u_dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sys_pll_lock(pll_s), .usb_pll_lock(pll_u), .usb_clk_state(ck_st),
    .strap_pins(strap_pins), .reset_cause(reset_cause), .fetch_addr(fetch_addr),
    .vector_remap_register(vmap), .vector_from_rom(rom), .vector_from_ram(ram),
    .interrupt_delay_setting(dly));

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // request held until pready is sampled high; one idle edge after release
  // no wait limit here: the cycle ceiling below ends a hang
  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      print_verdict();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    // live status and captured pin words are checked by the rows instead
    for (int i = 0; i < SCRB_NREG; i++)
      if (!(i inside {3, 5, 27, 28, 42}))
      begin
        apb(1'b0, {2'b00, SCRB_OFFSET[i]}, '0);
        check($sformatf("reset %h", SCRB_OFFSET[i]), rd, SCRB_RESET[i]);
      end
    foreach (rows[k])
    begin
      apb(rows[k].wr, rows[k].a, rows[k].d);
      check($sformatf("err %h", rows[k].a), 32'(err), 32'(rows[k].err));
      if (!rows[k].wr) check($sformatf("reg %h", rows[k].a), rd, rows[k].e);
    end
    // every legal map code against addresses on both sides of the window edge
    // the reserved code 3 is never written
    for (int m = 0; m < 3; m++)
    begin
      apb(1'b1, 14'h000, 32'(m));
      check("map", 32'(vmap), 32'(m));
      foreach (fa[j])
      begin
        fetch_addr <= fa[j];
        repeat (2) @(posedge pclk);
        check("rom", 32'(rom), 32'(m == 0 && fa[j] < 32'h200));
        check("ram", 32'(ram), 32'(m == 1 && fa[j] < 32'h200));
      end
    end
    // clock enable low freezes the redirect flag although the fetch moves
    apb(1'b1, 14'h000, 32'h0);
    pce <= 1'b0;
    fetch_addr <= 32'h0;
    repeat (2) @(posedge pclk);
    check("frozen rom", 32'(rom), 32'h0);
    pce <= 1'b1;
    repeat (2) @(posedge pclk);
    check("thawed rom", 32'(rom), 32'h1);
    // sticky cause bit, then a partial write-one-to-clear
    reset_cause <= 5'h04;
    @(posedge pclk);
    reset_cause <= 5'h00;
    apb(1'b0, 14'h030, '0);
    check("cause set", rd, 32'h7);
    apb(1'b1, 14'h030, 32'h5);
    apb(1'b0, 14'h030, '0);
    check("cause clr", rd, 32'h2);
    // second reset in mid-run, after map and delay were moved away from reset
    presetn <= 1'b0;
    @(posedge pclk);
    check("rst map", 32'(vmap), 32'h2);
    check("rst dly", 32'(dly), 32'h10);
    check("rst prdata", prdata, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, 14'h170, '0);
    check("dly read", rd, 32'h10);
    print_verdict();
  end
endmodule
